//--- eiw_ctrl.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Purpose: external event lines, vectored interrupt controller and low-power wake control
// Assumes: apb master per amba rules; core gives entry and return strobes
// Notes: one pclk domain apart from the edge capture flops
module eiw_ctrl
  import eiw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pprot_user,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [EIW_PINS-1:0] io_pins,
  input wire logic [EIW_NSRC-1:0] src_irq,
  input wire logic nmi_in,
  input wire logic core_take,
  input wire logic core_return,
  input wire logic core_wfi,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_reset,
  output logic line_event,
  output logic irq_req,
  output logic [EIW_VEC_W-1:0] irq_vec,
  output logic irq_direct,
  output logic [31:0] irq_target,
  output logic vt_instr_mode,
  output logic ctx_save,
  output logic ctx_restore,
  output logic tail_link,
  output logic core_clk_en,
  output logic hf_clk_en,
  output logic sysclk_sel_internal
);
  logic [EIW_LINES-1:0] imask_reg;
  logic [EIW_LINES-1:0] emask_reg;
  logic [EIW_LINES-1:0] rise_reg;
  logic [EIW_LINES-1:0] fall_reg;
  logic [EIW_LINES-1:0] pend_reg;
  logic [EIW_LINES-1:0] pend_next;
  logic [EIW_PSEL_W*EIW_LINES-1:0] psel_reg;
  logic [EIW_NSRC-1:0] irq_en_reg;
  logic [EIW_NSRC-1:0] irq_pend_reg;
  logic [31:0] cfg_reg;
  logic [31:0] fast0_reg;
  logic [31:0] fast1_reg;
  logic [1:0] pwr_req_reg;
  logic [EIW_LINES-1:0] line_hit;
  logic [EIW_LINES-1:0] line_pin;
  logic [EIW_VEC_W-1:0] stack_reg [EIW_DEPTH];
  logic [1:0] depth_reg;
  logic nmi_active_reg;
  eiw_pwr_t pwr_state_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic ext_wake;
  logic [EIW_NSRC-1:0] live_src;
  logic cand_valid;
  logic [EIW_VEC_W-1:0] cand_vec;
  logic nest_allowed;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ------------------------------------------------------------
  // apb slave, zero wait state
  // ------------------------------------------------------------
  // privilege is ignored: both user and machine may access all registers
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign addr_ok = (paddr <= EIW_OFS_PWR) & (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      imask_reg <= '0;
      emask_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
      psel_reg <= '0;
      irq_en_reg <= '0;
      cfg_reg <= 32'h00000000;
      fast0_reg <= 32'h00000000;
      fast1_reg <= 32'h00000000;
    end
    else if (wr_en)
    begin
      if (reg_hit(paddr, EIW_OFS_IMASK)) imask_reg <= pwdata[EIW_LINES-1:0];
      if (reg_hit(paddr, EIW_OFS_EMASK)) emask_reg <= pwdata[EIW_LINES-1:0];
      if (reg_hit(paddr, EIW_OFS_RISE)) rise_reg <= pwdata[EIW_LINES-1:0];
      if (reg_hit(paddr, EIW_OFS_FALL)) fall_reg <= pwdata[EIW_LINES-1:0];
      if (reg_hit(paddr, EIW_OFS_PSEL_LO)) psel_reg[29:0] <= pwdata[29:0];
      if (reg_hit(paddr, EIW_OFS_PSEL_HI)) psel_reg[49:30] <= pwdata[19:0];
      if (reg_hit(paddr, EIW_OFS_IRQ_EN)) irq_en_reg <= pwdata[EIW_NSRC-1:0];
      if (reg_hit(paddr, EIW_OFS_CFG)) cfg_reg <= pwdata;
      if (reg_hit(paddr, EIW_OFS_FAST0)) fast0_reg <= pwdata;
      if (reg_hit(paddr, EIW_OFS_FAST1)) fast1_reg <= pwdata;
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      unique case (paddr)
        EIW_OFS_IMASK: prdata = {22'h000000, imask_reg};
        EIW_OFS_EMASK: prdata = {22'h000000, emask_reg};
        EIW_OFS_RISE: prdata = {22'h000000, rise_reg};
        EIW_OFS_FALL: prdata = {22'h000000, fall_reg};
        EIW_OFS_PEND: prdata = {22'h000000, pend_reg};
        EIW_OFS_PSEL_LO: prdata = {2'b00, psel_reg[29:0]};
        EIW_OFS_PSEL_HI: prdata = {12'h000, psel_reg[49:30]};
        EIW_OFS_IRQ_EN: prdata = {3'b000, irq_en_reg};
        EIW_OFS_IRQ_PEND: prdata = {3'b000, irq_pend_reg};
        EIW_OFS_CFG: prdata = cfg_reg;
        EIW_OFS_FAST0: prdata = fast0_reg;
        EIW_OFS_FAST1: prdata = fast1_reg;
        EIW_OFS_STATUS: prdata = {14'h0000, nmi_active_reg, depth_reg, stack_reg[1], stack_reg[0][6:0]};
        EIW_OFS_PWR: prdata = {28'h0000000, pwr_state_reg, pwr_req_reg};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // external event lines
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < EIW_LINES; gi++)
    begin : g_line
      assign line_pin[gi] = io_pins[psel_reg[gi*EIW_PSEL_W +: EIW_PSEL_W] % EIW_PINS];
      eiw_edge_cell u_cell
      (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(line_pin[gi]),
        .rise_en(rise_reg[gi]),
        .fall_en(fall_reg[gi]),
        .ack(1'b0),
        .hit(line_hit[gi])
      );
    end
  endgenerate

  always_comb
  begin
    pend_next = pend_reg;
    if (wr_en && reg_hit(paddr, EIW_OFS_PEND))
      pend_next = pend_reg & ~pwdata[EIW_LINES-1:0];
    pend_next = pend_next | (line_hit & imask_reg);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= '0;
    else
      pend_reg <= pend_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_event <= 1'b0;
    else
      line_event <= |(line_hit & emask_reg);
  end

  // ------------------------------------------------------------
  // vectored interrupt controller
  // ------------------------------------------------------------
  // line pending feeds core source 0, the shared external line
  assign live_src = src_irq | {{(EIW_NSRC-1){1'b0}}, |pend_reg};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_pend_reg <= '0;
    else if (wr_en && reg_hit(paddr, EIW_OFS_IRQ_PEND))
      irq_pend_reg <= (irq_pend_reg & ~pwdata[EIW_NSRC-1:0]) | live_src;
    else
      irq_pend_reg <= irq_pend_reg | live_src;
  end

  always_comb
  begin
    cand_valid = 1'b0;
    cand_vec = '0;
    for (int i = EIW_NSRC - 1; i >= 0; i--)
    begin
      if (irq_pend_reg[i] && irq_en_reg[i])
      begin
        cand_valid = 1'b1;
        cand_vec = (i < EIW_CORE_SRC) ? EIW_VEC_W'(i) : EIW_PERIPH_BASE + EIW_VEC_W'(i);
      end
    end
    if (nmi_in)
    begin
      cand_valid = 1'b1;
      cand_vec = EIW_NMI_VEC;
    end
  end

  assign nest_allowed = (depth_reg == 2'd0)
                      || (cfg_reg[EIW_CFG_NEST_BIT] && depth_reg < 2'(EIW_DEPTH));
  assign irq_req = cand_valid && cand_vec <= EIW_VEC_MAX
                && (nest_allowed || (nmi_in && !nmi_active_reg));
  assign irq_vec = cand_vec;
  assign vt_instr_mode = cfg_reg[EIW_CFG_VTMODE_BIT];

  always_comb
  begin
    irq_direct = 1'b0;
    irq_target = 32'h00000000;
    if (cfg_reg[EIW_CFG_FAST0_EN_BIT] && cand_vec == cfg_reg[EIW_CFG_FID0_LSB +: EIW_VEC_W])
    begin
      irq_direct = 1'b1;
      irq_target = fast0_reg;
    end
    else if (cfg_reg[EIW_CFG_FAST1_EN_BIT] && cand_vec == cfg_reg[EIW_CFG_FID1_LSB +: EIW_VEC_W])
    begin
      irq_direct = 1'b1;
      irq_target = fast1_reg;
    end
  end

  // tail link: return while another request waits at the same level
  assign tail_link = core_return && irq_req && depth_reg == 2'd1;
  assign ctx_save = core_take && irq_req && !(core_return && depth_reg == 2'd1);
  assign ctx_restore = core_return && !tail_link;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      depth_reg <= 2'd0;
      stack_reg[0] <= '0;
      stack_reg[1] <= '0;
      nmi_active_reg <= 1'b0;
    end
    else if (tail_link)
      stack_reg[0] <= cand_vec;
    else if (core_take && irq_req && depth_reg < 2'(EIW_DEPTH))
    begin
      stack_reg[depth_reg[0]] <= cand_vec;
      depth_reg <= depth_reg + 2'd1;
      if (cand_vec == EIW_NMI_VEC)
        nmi_active_reg <= 1'b1;
    end
    else if (core_return && depth_reg != 2'd0)
    begin
      depth_reg <= depth_reg - 2'd1;
      if (stack_reg[depth_reg[1] ? 1 : 0] == EIW_NMI_VEC)
        nmi_active_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // low power control
  // ------------------------------------------------------------
  assign ext_wake = (|(line_hit & (imask_reg | emask_reg))) || !ext_reset_pin_n || watchdog_reset;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_req_reg <= 2'b00;
    else if (wr_en && reg_hit(paddr, EIW_OFS_PWR))
      pwr_req_reg <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_state_reg <= EIW_PWR_RUN;
    else
    begin
      unique case (pwr_state_reg)
        EIW_PWR_RUN:
          if (core_wfi && pwr_req_reg[EIW_PWR_DEEP_BIT])
            pwr_state_reg <= EIW_PWR_STANDBY;
          else if (core_wfi && pwr_req_reg[EIW_PWR_SLEEP_BIT])
            pwr_state_reg <= EIW_PWR_SLEEP;
        EIW_PWR_SLEEP:
          if (cand_valid || line_event || ext_wake)
            pwr_state_reg <= EIW_PWR_RUN;
        EIW_PWR_STANDBY:
          if (ext_wake)
            pwr_state_reg <= EIW_PWR_RUN;
        default: pwr_state_reg <= EIW_PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sysclk_sel_internal <= 1'b1;
    else if (pwr_state_reg == EIW_PWR_STANDBY && ext_wake)
      sysclk_sel_internal <= 1'b1;
    else if (wr_en && reg_hit(paddr, EIW_OFS_PWR))
      sysclk_sel_internal <= ~pwdata[2];
  end

  // registers and memory keep state; only clock enables change
  assign core_clk_en = (pwr_state_reg == EIW_PWR_RUN);
  assign hf_clk_en = (pwr_state_reg != EIW_PWR_STANDBY);
endmodule // eiw_ctrl

//--- eiw_pkg.sv
// Purpose: constants, register map and types for the edge interrupt and wake control block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
//
// Contract
// - ten independent edge detector lines, each raising interrupt or event requests
// - per-line trigger select: rising, falling or both edges
// - per-line mask; masked line raises nothing, others keep working
// - pending register holds one status bit per line
// - pulses shorter than a bus clock period are still caught
// - any of eighteen io pins selectable as a line source
// - vector space up to 255 (requests raised only up to vector 254); 4 core and 25 peripheral sources used
// - one non-maskable input never blocked by masks
// - nesting configurable, at most two levels, two-level hardware stack
// - context saved and restored by hardware on entry and return
// - two table-free fast vector slots jump straight to handler address
// - vector table entries read as addresses or instructions by mode
// - pending interrupt at return from level one is entered directly by tail linking, if nesting is enabled or it is the nmi
// - all controller registers reachable from user and machine privilege
// - sleep gates only core clock; any interrupt or event wakes
// - standby wakes on enabled line, reset pin or watchdog reset
// - standby stops hf domain, keeps state; wakes on internal oscillator
package eiw_pkg;
  localparam int EIW_LINES = 10;
  localparam int EIW_PINS = 18;
  localparam int EIW_PSEL_W = 5;
  localparam int EIW_NSRC = 29;
  localparam int EIW_CORE_SRC = 4;
  localparam int EIW_VEC_W = 8;
  localparam int EIW_DEPTH = 2;
  localparam logic [7:0] EIW_VEC_MAX = 8'hfe;
  localparam logic [7:0] EIW_NMI_VEC = 8'h02;
  localparam logic [7:0] EIW_PERIPH_BASE = 8'h10;

  localparam logic [7:0] EIW_OFS_IMASK = 8'h00;
  localparam logic [7:0] EIW_OFS_EMASK = 8'h04;
  localparam logic [7:0] EIW_OFS_RISE = 8'h08;
  localparam logic [7:0] EIW_OFS_FALL = 8'h0c;
  localparam logic [7:0] EIW_OFS_PEND = 8'h10;
  localparam logic [7:0] EIW_OFS_PSEL_LO = 8'h14;
  localparam logic [7:0] EIW_OFS_PSEL_HI = 8'h18;
  localparam logic [7:0] EIW_OFS_IRQ_EN = 8'h1c;
  localparam logic [7:0] EIW_OFS_IRQ_PEND = 8'h20;
  localparam logic [7:0] EIW_OFS_CFG = 8'h24;
  localparam logic [7:0] EIW_OFS_FAST0 = 8'h28;
  localparam logic [7:0] EIW_OFS_FAST1 = 8'h2c;
  localparam logic [7:0] EIW_OFS_STATUS = 8'h30;
  localparam logic [7:0] EIW_OFS_PWR = 8'h34;

  // cfg register fields
  localparam int EIW_CFG_NEST_BIT = 0;
  localparam int EIW_CFG_VTMODE_BIT = 1;
  localparam int EIW_CFG_FAST0_EN_BIT = 2;
  localparam int EIW_CFG_FAST1_EN_BIT = 3;
  localparam int EIW_CFG_FID0_LSB = 8;
  localparam int EIW_CFG_FID1_LSB = 16;
  // pwr register fields
  localparam int EIW_PWR_SLEEP_BIT = 0;
  localparam int EIW_PWR_DEEP_BIT = 1;

  typedef enum logic [1:0] {
    EIW_PWR_RUN = 2'b00,
    EIW_PWR_SLEEP = 2'b01,
    EIW_PWR_STANDBY = 2'b10
  } eiw_pwr_t;
endpackage : eiw_pkg

//--- eiw_edge_cell.sv
`timescale 1ns/1ps
// Purpose: one edge detector line, catches pulses narrower than a clock period
// Assumes: pin_in may toggle at any time; clear is synchronous to pclk
// Notes: the pin itself clocks the capture flops
module eiw_edge_cell
  import eiw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic ack,
  output logic hit
);
  logic rise_cap_reg;
  logic fall_cap_reg;
  logic rise_ack_reg;
  logic fall_ack_reg;
  logic [1:0] rise_sync_reg;
  logic [1:0] fall_sync_reg;
  logic rise_seen_reg;
  logic fall_seen_reg;

  // ------------------------------------------------------------
  // asynchronous capture on the pin edge itself
  // ------------------------------------------------------------
  // toggles flip on each edge so no pulse is too short to be seen
  always_ff @(posedge pin_in or negedge presetn)
  begin
    if (!presetn)
      rise_cap_reg <= 1'b0;
    else
      rise_cap_reg <= ~rise_cap_reg;
  end

  always_ff @(negedge pin_in or negedge presetn)
  begin
    if (!presetn)
      fall_cap_reg <= 1'b0;
    else
      fall_cap_reg <= ~fall_cap_reg;
  end

  // ------------------------------------------------------------
  // crossing into pclk
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_sync_reg <= 2'b00;
      fall_sync_reg <= 2'b00;
      rise_seen_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
    end
    else
    begin
      rise_sync_reg <= {rise_sync_reg[0], rise_cap_reg};
      fall_sync_reg <= {fall_sync_reg[0], fall_cap_reg};
      rise_seen_reg <= rise_sync_reg[1];
      fall_seen_reg <= fall_sync_reg[1];
    end
  end

  // ack registers follow ack but are never read; hit does not use them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_ack_reg <= 1'b0;
      fall_ack_reg <= 1'b0;
    end
    else
    begin
      rise_ack_reg <= ack;
      fall_ack_reg <= ack;
    end
  end

  assign hit = ((rise_sync_reg[1] ^ rise_seen_reg) & rise_en)
             | ((fall_sync_reg[1] ^ fall_seen_reg) & fall_en);
endmodule // eiw_edge_cell

//--- eiw_core_model.sv
// Purpose: behavioural core that takes and returns interrupts
// Assumes: bench asks for each take and return
// Notes: takes only a request still present after lat cycles
`timescale 1ns/1ps
module eiw_core_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic take_cmd,
  input wire logic ret_cmd,
  input wire logic [3:0] lat,
  output logic core_take,
  output logic core_return
);
  // --------
  // handshake
  // --------
  logic [3:0] wait_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg <= 4'h0;
      core_take <= 1'b0;
      core_return <= 1'b0;
    end
    else
    begin
      core_return <= ret_cmd;
      // a request withdrawn before lat runs out is never taken
      core_take <= take_cmd && irq_req && !core_take && wait_reg >= lat;
      wait_reg <= (take_cmd && irq_req && !core_take) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule // eiw_core_model

//--- eiw_chk.sv
// Purpose: port checker for eiw_ctrl
// Assumes: single pclk domain
// Notes: bound to every eiw_ctrl instance
`timescale 1ns/1ps
module eiw_chk
  import eiw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pprot_user,
  input wire logic pslverr,
  input wire logic nmi_in,
  input wire logic core_take,
  input wire logic core_return,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic irq_req,
  input wire logic [EIW_VEC_W-1:0] irq_vec,
  input wire logic vt_instr_mode,
  input wire logic ctx_save,
  input wire logic ctx_restore,
  input wire logic tail_link,
  input wire logic core_clk_en,
  input wire logic hf_clk_en,
  input wire logic sysclk_sel_internal
);
  // --------
  // properties
  // --------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic vt_bit_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vt_bit_reg <= 1'b0;
    else
      vt_bit_reg <= pwdata[EIW_CFG_VTMODE_BIT];
  end
  a_nmi_vec: assert property (nmi_in && irq_req |-> irq_vec == EIW_NMI_VEC)
    else $error("nmi vector wrong");
  a_ctx_save: assert property (core_take && !core_return |-> ctx_save)
    else $error("no context save on entry");
  a_ctx_restore: assert property (core_return && !irq_req |-> ctx_restore && !tail_link)
    else $error("no context restore on return");
  a_tail_skip: assert property (tail_link |-> core_return && !ctx_restore && !ctx_save)
    else $error("tail link shape wrong");
  a_wake_reset: assert property (!ext_reset_pin_n || watchdog_reset |-> ##[0:2] core_clk_en && hf_clk_en)
    else $error("no wake on reset cause");
  a_core_needs_hf: assert property (core_clk_en |-> hf_clk_en)
    else $error("core clock without hf domain");
  a_int_osc: assert property ($rose(hf_clk_en) |-> ##[0:1] sysclk_sel_internal)
    else $error("wake not on internal oscillator");
  a_priv_any: assert property (psel && penable && pprot_user && paddr <= EIW_OFS_PWR && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("user access refused");
  a_vt_mode: assert property (psel && penable && pwrite && paddr == EIW_OFS_CFG |=> vt_instr_mode == vt_bit_reg)
    else $error("vector mode not updated");
  a_irq_hold: assert property (irq_req && !nmi_in && !core_take && !core_return && !(psel && pwrite)
    |=> irq_req)
    else $error("request lost without clear");
  cp_tail: cover property (tail_link);
  cp_nmi: cover property (nmi_in && irq_req);
  cp_sleep: cover property (!core_clk_en && hf_clk_en);
endmodule // eiw_chk

bind eiw_ctrl eiw_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot_user,
  .pslverr, .nmi_in, .core_take, .core_return, .ext_reset_pin_n, .watchdog_reset, .irq_req, .irq_vec,
  .vt_instr_mode, .ctx_save, .ctx_restore, .tail_link, .core_clk_en, .hf_clk_en, .sysclk_sel_internal);

//--- edge_interrupt_and_wake_control_tb.sv
// Purpose: self-checking bench for eiw_ctrl
// Assumes: zero-wait apb slave, core model answers take and return
// Notes: the short pin pulse is placed between clock edges on purpose
`timescale 1ns/1ps
module edge_interrupt_and_wake_control_tb;
  import eiw_pkg::*;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, pprot_user = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, irq_target, q;
  logic [EIW_PINS-1:0] io_pins = '0;
  logic [EIW_NSRC-1:0] src_irq = '0;
  logic nmi_in = 0, core_wfi = 0, ext_reset_pin_n = 1, watchdog_reset = 0, take_cmd = 0, ret_cmd = 0;
  logic pready, pslverr, line_event, irq_req, irq_direct, vt_instr_mode, ctx_save, ctx_restore, e;
  logic tail_link, core_clk_en, hf_clk_en, sysclk_sel_internal, core_take, core_return;
  logic [EIW_VEC_W-1:0] irq_vec;
  int fail_count = 0, checks = 0;
  always #2.5 pclk = ~pclk;
  eiw_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot_user, .prdata, .pready,
    .pslverr, .io_pins, .src_irq, .nmi_in, .core_take, .core_return, .core_wfi, .ext_reset_pin_n,
    .watchdog_reset, .line_event, .irq_req, .irq_vec, .irq_direct, .irq_target, .vt_instr_mode, .ctx_save,
    .ctx_restore, .tail_link, .core_clk_en, .hf_clk_en, .sysclk_sel_internal);
  eiw_core_model u_core (.pclk, .presetn, .irq_req, .take_cmd, .ret_cmd, .lat(4'd2), .core_take, .core_return);
  // --------
  // helpers
  // --------
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(0, a, 32'h0);
    cmp(n, x, q);
  endtask
  task automatic wait_hi(ref logic s, input string n);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    cmp(n, 32'h1, {31'h0, s});
  endtask
  task automatic pin_pulse(input int i);
    @(posedge pclk);
    io_pins[i] <= 1;
    cyc(3);
    io_pins[i] <= 0;
    cyc(4);
  endtask
  task automatic do_reset();
    presetn <= 0;
    src_irq <= '0;
    cyc(8);
    presetn <= 1;
    cyc(1);
  endtask
  task automatic take();
    take_cmd <= 1;
    wait_hi(core_take, "take");
    take_cmd <= 0;
    cyc(2);
  endtask
  task automatic give_back();
    ret_cmd <= 1;
    @(posedge pclk);
    ret_cmd <= 0;
  endtask
  task automatic wfi();
    core_wfi <= 1;
    @(posedge pclk);
    core_wfi <= 0;
    cyc(2);
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_regs();
    rd(EIW_OFS_PEND, 32'h0, "pend reset");
    cmp("sysclk reset", 32'h1, {31'h0, sysclk_sel_internal});
    pprot_user <= 1;
    apb(0, 8'h38, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, e});
    wr(EIW_OFS_CFG, 32'h2);
    rd(EIW_OFS_CFG, 32'h2, "cfg user");
    cmp("vt mode", 32'h1, {31'h0, vt_instr_mode});
  endtask
  task automatic t_edges();
    logic r, f;
    wr(EIW_OFS_IMASK, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      r = (m != 1);
      f = (m != 0);
      wr(EIW_OFS_RISE, {31'h0, r});
      wr(EIW_OFS_FALL, {31'h0, f});
      io_pins[0] <= 1;
      cyc(6);
      rd(EIW_OFS_PEND, {31'h0, r}, "pend rise");
      wr(EIW_OFS_PEND, 32'h1);
      rd(EIW_OFS_PEND, 32'h0, "pend clear");
      io_pins[0] <= 0;
      cyc(6);
      rd(EIW_OFS_PEND, {31'h0, f}, "pend fall");
      wr(EIW_OFS_PEND, 32'h1);
    end
    wr(EIW_OFS_FALL, 32'h0);
  endtask
  task automatic t_lines();
    wr(EIW_OFS_IMASK, 32'h202);
    wr(EIW_OFS_RISE, 32'h203);
    wr(EIW_OFS_PSEL_LO, 32'h20);
    wr(EIW_OFS_PSEL_HI, 32'h88000);
    pin_pulse(0);
    pin_pulse(1);
    rd(EIW_OFS_PEND, 32'h2, "pend masked");
    pin_pulse(17);
    rd(EIW_OFS_PEND, 32'h202, "pend pin sel");
    wr(EIW_OFS_PEND, 32'h3ff);
    #1 io_pins[1] = 1;
    #2 io_pins[1] = 0;
    cyc(6);
    rd(EIW_OFS_PEND, 32'h2, "pend short");
    wr(EIW_OFS_EMASK, 32'h1);
    io_pins[0] <= 1;
    wait_hi(line_event, "line event");
    io_pins[0] <= 0;
  endtask
  task automatic t_irq();
    nmi_in <= 1;
    cyc(2);
    cmp("nmi vec", {24'h0, EIW_NMI_VEC}, {24'h0, irq_vec});
    nmi_in <= 0;
    wr(EIW_OFS_IRQ_EN, 32'h0210_0000);
    wr(EIW_OFS_FAST0, 32'h1234);
    wr(EIW_OFS_CFG, 32'h2407);
    src_irq[20] <= 1;
    wait_hi(irq_req, "irq req");
    cmp("irq vec", 32'h24, {24'h0, irq_vec});
    cmp("fast hit", 32'h1234_0001, {irq_target[15:0], 15'h0, irq_direct});
    take();
    src_irq[20] <= 0;
    wr(EIW_OFS_IRQ_PEND, 32'h0010_0000);
    src_irq[25] <= 1;
    cyc(3);
    cmp("nest req", 32'h129, {23'h0, irq_req, irq_vec});
    give_back();
    wait_hi(tail_link, "tail link");
    do_reset();
    src_irq[20] <= 1;
    wr(EIW_OFS_IRQ_EN, 32'h0010_0000);
    take();
    cmp("no nest", 32'h0, {31'h0, irq_req});
    give_back();
    cyc(2);
  endtask
  task automatic t_power();
    wr(EIW_OFS_EMASK, 32'h1);
    wr(EIW_OFS_RISE, 32'h1);
    wr(EIW_OFS_PWR, 32'h1);
    wfi();
    cmp("sleep clks", 32'h1, {30'h0, core_clk_en, hf_clk_en});
    pin_pulse(0);
    cmp("sleep wake", 32'h3, {30'h0, core_clk_en, hf_clk_en});
    for (int c = 0; c < 3; c++)
    begin
      wr(EIW_OFS_PWR, 32'h6);
      cyc(2);
      cmp("ext clk sel", 32'h0, {31'h0, sysclk_sel_internal});
      wfi();
      cmp("standby clks", 32'h0, {30'h0, core_clk_en, hf_clk_en});
      ext_reset_pin_n <= (c != 1);
      watchdog_reset <= (c == 2);
      io_pins[0] <= (c == 0);
      wait_hi(hf_clk_en, "standby wake");
      cmp("wake clk", 32'h3, {30'h0, core_clk_en, sysclk_sel_internal});
      ext_reset_pin_n <= 1;
      watchdog_reset <= 0;
      io_pins[0] <= 0;
      cyc(2);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_regs();
    t_edges();
    t_lines();
    t_irq();
    do_reset();
    t_power();
    end_sim();
  end
  initial
  begin
    #50us;
    fail_count++;
    end_sim();
  end
endmodule // edge_interrupt_and_wake_control_tb
